// ---- crt_mon.sv ----
// monitor model measuring sync and display timing in mclk cycles
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------
// monitor
// ---------------------------------------------
module crt_mon (
  input wire logic   mclk,
  input wire logic   rstn,
  input wire logic   hsync,
  input wire logic   vsync,
  input wire logic   vdisp,
  output logic [15:0] h_period,
  output logic [15:0] h_width,
  output logic [15:0] v_period,
  output logic [15:0] v_width,
  output logic [15:0] vd_cnt
);
  logic [15:0] now, h_rise, v_rise, vd_acc;
  logic        hs_q, vs_q;
  // edge timestamps; a real tube only sees edges, not levels
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      {now, h_rise, v_rise, vd_acc, hs_q, vs_q} <= '0;
      {h_period, h_width, v_period, v_width, vd_cnt} <= '0;
    end else begin
      now <= now + 16'h0001;
      hs_q <= hsync;
      vs_q <= vsync;
      if (hsync && !hs_q) begin
        h_period <= now - h_rise;
        h_rise <= now;
      end
      if (!hsync && hs_q) h_width <= now - h_rise;
      if (!vsync && vs_q) v_width <= now - v_rise;
      if (vsync && !vs_q) begin
        v_period <= now - v_rise;
        v_rise <= now;
        vd_cnt <= vd_acc;
        vd_acc <= {15'h0000, vdisp};
      end else vd_acc <= vd_acc + {15'h0000, vdisp};
    end
  end
endmodule : crt_mon
`default_nettype wire

// ---- crt_params.svh ----
// constants for the raster timing block
`ifndef CRT_PARAMS_SVH
`define CRT_PARAMS_SVH
`define CRT_CHAR_DIV      8
`define CRT_HTOTAL_ADD    9'h005
`define CRT_VTOTAL_ADD    11'h002
`define CRT_IDX_HSS       6'h04
`define CRT_IDX_HSE       6'h05
`define CRT_IDX_VTOT      6'h06
`define CRT_IDX_OVF       6'h07
`define CRT_IDX_PRESET    6'h08
`define CRT_IDX_MAXSCAN   6'h09
`define CRT_IDX_CURS_ST   6'h0A
`define CRT_IDX_CURS_END  6'h0B
`define CRT_IDX_START_HI  6'h0C
`define CRT_IDX_START_LO  6'h0D
`define CRT_IDX_CLOC_HI   6'h0E
`define CRT_IDX_CLOC_LO   6'h0F
`define CRT_IDX_VSS       6'h10
`define CRT_IDX_VSE       6'h11
`define CRT_IDX_VDE       6'h12
`define CRT_IDX_PITCH     6'h13
`define CRT_IDX_UNDERLINE 6'h14
`define CRT_OVF_LC8       4
`define CRT_VSE_ICLR      4
`define CRT_VSE_IDIS      5
`define CRT_VSE_REFR      6
`define CRT_VSE_PROT      7
`define CRT_CURS_OFF      5
`define CRT_MAX_DSCAN     7
`define CRT_REFRESH_LO    3'h3
`define CRT_REFRESH_HI    3'h5
`define CRT_UL_ADD        5'h01
`endif

// ---- crt_pkg.sv ----
// types shared by the raster timing block
package crt_pkg;
  typedef enum logic [1:0] {CRT_BYTE, CRT_WORD, CRT_DWORD} crt_mode_e;
  typedef logic [15:0] crt_addr_t;
endpackage : crt_pkg

// ---- crt_raster_timing_regs.sv ----
// raster timing, cursor and indexed register file
//
// Operation
// - pen select low returns readback at 10h/11h
// - hsync starts at start count
// - hsync ends on low five bit match
// - hsync skew bits; bit7 blank end bit5
// - frame lines equal vertical total plus two
// - overflow register supplies high order bits
// - row scan preset, increment, clear, panning
// - lines per row is field plus one
// - double scan repeats lines, timing unchanged
// - cursor start line and off bit
// - cursor end line and cursor skew
// - start above end hides; end clamped
// - display start and cursor location addresses
// - readback loaded at line compare, read only
// - vsync starts at ten bit line
// - vsync ends on low four bit match
// - vertical interrupt clear and enable bits
// - refresh type selects three or five
// - group zero write protect
// - vertical display end is value plus one
// - row start advances by K times pitch
// - underline on field plus one
`timescale 1ns/1ps
`default_nettype none
`include "crt_params.svh"
module crt_raster_timing_regs #(
  parameter int CHAR_DIV = `CRT_CHAR_DIV
) (
  input  wire logic              mclk,
  input  wire logic              rstn,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [5:0]        reg_index,
  input  wire logic [7:0]        reg_wdata,
  output logic      [7:0]        reg_rdata,
  input  wire logic              pen_sel,
  input  wire logic              ext_protect,
  input  wire logic              ext_mode,
  input  wire logic              ext_hss_b8,
  input  wire logic              ext_hse_b5,
  input  wire logic              ext_vtot_b10,
  input  wire logic              ext_vde_b10,
  input  wire logic              ext_vss_b10,
  input  wire logic [7:0]        htotal,
  input  wire crt_pkg::crt_mode_e addr_mode,
  input  wire logic [9:0]        line_compare,
  output logic                   hsync,
  output logic                   vsync,
  output logic                   vdisp,
  output logic                   cursor,
  output logic                   underline,
  output logic                   irq,
  output logic      [4:0]        row_scan,
  output crt_pkg::crt_addr_t     mem_addr,
  output logic      [1:0]        byte_pan,
  output logic                   hblank_end_b5,
  output logic      [2:0]        refresh_cycles
);
  import crt_pkg::*;

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [7:0]  hsync_start_reg;
  logic [7:0]  hsync_end_reg;
  logic [7:0]  vertical_total_reg;
  logic [7:0]  vertical_overflow_reg;
  logic [7:0]  preset_row_scan_reg;
  logic [7:0]  max_scan_line_reg;
  logic [7:0]  cursor_start_reg;
  logic [7:0]  cursor_end_reg;
  logic [7:0]  display_start_high_reg;
  logic [7:0]  display_start_low_reg;
  logic [7:0]  cursor_location_high_reg;
  logic [7:0]  cursor_location_low_reg;
  logic [7:0]  vsync_start_reg;
  logic [7:0]  vsync_end_reg;
  logic [7:0]  vertical_display_end_reg;
  logic [7:0]  row_pitch_reg;
  logic [7:0]  underline_location_reg;
  crt_addr_t   pen_readback_reg;
  logic        protect;

  assign protect = vsync_end_reg[`CRT_VSE_PROT] | ext_protect;

  // group zero writes are dropped while protected, except the overflow line compare bit
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      hsync_start_reg       <= 8'h00;
      hsync_end_reg         <= 8'h00;
      vertical_total_reg    <= 8'h00;
      vertical_overflow_reg <= 8'h00;
    end else if (reg_wr) begin
      if (!protect) begin
        unique case (reg_index)
          `CRT_IDX_HSS:  hsync_start_reg       <= reg_wdata;
          `CRT_IDX_HSE:  hsync_end_reg         <= reg_wdata;
          `CRT_IDX_VTOT: vertical_total_reg    <= reg_wdata;
          `CRT_IDX_OVF:  vertical_overflow_reg <= reg_wdata;
          default: ;
        endcase
      end else if (reg_index == `CRT_IDX_OVF) begin
        // line compare bit stays open to software
        vertical_overflow_reg[`CRT_OVF_LC8] <= reg_wdata[`CRT_OVF_LC8];
      end
    end
  end

  // unprotected registers of this stretch
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      preset_row_scan_reg      <= 8'h00;
      max_scan_line_reg        <= 8'h00;
      cursor_start_reg         <= 8'h00;
      cursor_end_reg           <= 8'h00;
      display_start_high_reg   <= 8'h00;
      display_start_low_reg    <= 8'h00;
      cursor_location_high_reg <= 8'h00;
      cursor_location_low_reg  <= 8'h00;
      vsync_start_reg          <= 8'h00;
      vsync_end_reg            <= 8'h00;
      vertical_display_end_reg <= 8'h00;
      row_pitch_reg            <= 8'h00;
      underline_location_reg   <= 8'h00;
    end else if (reg_wr) begin
      unique case (reg_index)
        `CRT_IDX_PRESET:    preset_row_scan_reg      <= reg_wdata;
        `CRT_IDX_MAXSCAN:   max_scan_line_reg        <= reg_wdata;
        `CRT_IDX_CURS_ST:   cursor_start_reg         <= reg_wdata;
        `CRT_IDX_CURS_END:  cursor_end_reg           <= reg_wdata;
        `CRT_IDX_START_HI:  display_start_high_reg   <= reg_wdata;
        `CRT_IDX_START_LO:  display_start_low_reg    <= reg_wdata;
        `CRT_IDX_CLOC_HI:   cursor_location_high_reg <= reg_wdata;
        `CRT_IDX_CLOC_LO:   cursor_location_low_reg  <= reg_wdata;
        `CRT_IDX_VSS:       vsync_start_reg          <= reg_wdata;
        `CRT_IDX_VSE:       vsync_end_reg            <= reg_wdata;
        `CRT_IDX_VDE:       vertical_display_end_reg <= reg_wdata;
        `CRT_IDX_PITCH:     row_pitch_reg            <= reg_wdata;
        `CRT_IDX_UNDERLINE: underline_location_reg   <= reg_wdata;
        default: ;
      endcase
    end
  end

  // read data; sync pair and pen readback share 10h/11h
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_index)
        `CRT_IDX_HSS:       reg_rdata <= hsync_start_reg;
        `CRT_IDX_HSE:       reg_rdata <= hsync_end_reg;
        `CRT_IDX_VTOT:      reg_rdata <= vertical_total_reg;
        `CRT_IDX_OVF:       reg_rdata <= vertical_overflow_reg;
        `CRT_IDX_PRESET:    reg_rdata <= preset_row_scan_reg;
        `CRT_IDX_MAXSCAN:   reg_rdata <= max_scan_line_reg;
        `CRT_IDX_CURS_ST:   reg_rdata <= cursor_start_reg;
        `CRT_IDX_CURS_END:  reg_rdata <= cursor_end_reg;
        `CRT_IDX_START_HI:  reg_rdata <= display_start_high_reg;
        `CRT_IDX_START_LO:  reg_rdata <= display_start_low_reg;
        `CRT_IDX_CLOC_HI:   reg_rdata <= cursor_location_high_reg;
        `CRT_IDX_CLOC_LO:   reg_rdata <= cursor_location_low_reg;
        // sync pair is write-only while pen select is high
        `CRT_IDX_VSS:       reg_rdata <= pen_sel ? 8'h00 : pen_readback_reg[15:8];
        `CRT_IDX_VSE:       reg_rdata <= pen_sel ? 8'h00 : pen_readback_reg[7:0];
        `CRT_IDX_VDE:       reg_rdata <= vertical_display_end_reg;
        `CRT_IDX_PITCH:     reg_rdata <= row_pitch_reg;
        `CRT_IDX_UNDERLINE: reg_rdata <= underline_location_reg;
        default:            reg_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // decoded timing values
  // ----------------------------------------------------------------
  logic [8:0]  hss;
  logic [8:0]  hlast;
  logic [10:0] vtot;
  logic [10:0] vss;
  logic [10:0] vde_val;
  logic [9:0]  lc_val;
  logic [4:0]  max_row;
  logic [4:0]  row_scan_reg;
  logic [4:0]  curs_end_eff;
  logic        curs_line_ok;

  assign hss     = {ext_mode & ext_hss_b8, hsync_start_reg};
  assign hlast   = {1'b0, htotal} + `CRT_HTOTAL_ADD - 9'h001;
  assign vtot    = {ext_mode & ext_vtot_b10, vertical_overflow_reg[5],
                    vertical_overflow_reg[0], vertical_total_reg};
  assign vss     = {ext_mode & ext_vss_b10, vertical_overflow_reg[7],
                    vertical_overflow_reg[2], vsync_start_reg};
  assign vde_val = {ext_mode & ext_vde_b10, vertical_overflow_reg[6],
                    vertical_overflow_reg[1], vertical_display_end_reg};
  // line compare comes in on the port but for bit 8, which sits in the overflow byte
  assign lc_val  = {line_compare[9], vertical_overflow_reg[`CRT_OVF_LC8],
                    line_compare[7:0]};
  assign max_row = max_scan_line_reg[4:0];
  // an end beyond the cell stops at the cell's last line
  assign curs_end_eff = (cursor_end_reg[4:0] > max_row) ? max_row
                                                        : cursor_end_reg[4:0];
  assign curs_line_ok = !cursor_start_reg[`CRT_CURS_OFF]
                     && (cursor_start_reg[4:0] <= cursor_end_reg[4:0])
                     && (row_scan_reg >= cursor_start_reg[4:0])
                     && (row_scan_reg <= curs_end_eff);

  // ----------------------------------------------------------------
  // character and scan line counters
  // ----------------------------------------------------------------
  logic [$clog2(CHAR_DIV)-1:0] div_reg;
  logic        char_en;
  logic [8:0]  hcnt_reg;
  logic [10:0] vcnt_reg;
  logic [10:0] vcnt_next;
  logic        line_end;
  logic        frame_wrap;

  // character clock as a one-cycle enable
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      div_reg <= '0;
      char_en <= 1'b0;
    end else begin
      char_en <= (div_reg == ($clog2(CHAR_DIV))'(CHAR_DIV - 1));
      div_reg <= (div_reg == ($clog2(CHAR_DIV))'(CHAR_DIV - 1)) ? '0 : div_reg + 1'b1;
    end
  end

  assign line_end   = char_en && (hcnt_reg == hlast);
  assign frame_wrap = (vcnt_reg == vtot + 11'h001);
  assign vcnt_next  = frame_wrap ? 11'h000 : vcnt_reg + 11'h001;

  // horizontal and vertical position counters
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      hcnt_reg <= 9'h000;
      vcnt_reg <= 11'h000;
    end else if (char_en) begin
      hcnt_reg <= line_end ? 9'h000 : hcnt_reg + 9'h001;
      if (line_end) begin
        vcnt_reg <= vcnt_next;
      end
    end
  end

  // ----------------------------------------------------------------
  // sync generation
  // ----------------------------------------------------------------
  logic hsync_raw_reg;
  logic vsync_reg;
  logic vint_reg;
  logic hse_hit;

  // sixth end bit takes part only in extended modes
  assign hse_hit = (hcnt_reg[4:0] == hsync_end_reg[4:0])
                && (!ext_mode || hcnt_reg[5] == ext_hse_b5);

  // horizontal sync before skew
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      hsync_raw_reg <= 1'b0;
    end else if (char_en) begin
      if (hcnt_reg == hss) begin
        hsync_raw_reg <= 1'b1;
      end else if (hse_hit) begin
        hsync_raw_reg <= 1'b0;
      end
    end
  end

  // vertical sync, decided once per line
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      vsync_reg <= 1'b0;
    end else if (line_end) begin
      if (vcnt_next == vss) begin
        vsync_reg <= 1'b1;
      end else if (vcnt_next[3:0] == vsync_end_reg[3:0]) begin
        vsync_reg <= 1'b0;
      end
    end
  end

  // pending vertical interrupt; a new event beats a held clear
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      vint_reg <= 1'b0;
    end else if (line_end && vcnt_next == vss && !vsync_end_reg[`CRT_VSE_IDIS]) begin
      vint_reg <= 1'b1;
    end else if (!vsync_end_reg[`CRT_VSE_ICLR]) begin
      vint_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // row scan and row addressing
  // ----------------------------------------------------------------
  logic        dscan_ph_reg;
  crt_addr_t   row_addr_reg;
  crt_addr_t   row_step;
  crt_addr_t   char_addr;
  logic        vdisp_now;

  assign vdisp_now = (vcnt_reg <= vde_val);
  assign char_addr = row_addr_reg + {7'h00, hcnt_reg};

  // pitch scaled by the addressing mode
  always_comb begin
    unique case (addr_mode)
      CRT_WORD:  row_step = {6'h00, row_pitch_reg, 2'h0};
      CRT_DWORD: row_step = {5'h00, row_pitch_reg, 3'h0};
      default:   row_step = {7'h00, row_pitch_reg, 1'h0};
    endcase
  end

  // row counter; double scan repeats each line, vertical timing untouched
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      row_scan_reg <= 5'h00;
      dscan_ph_reg <= 1'b0;
      row_addr_reg <= 16'h0000;
    end else if (line_end) begin
      if (frame_wrap) begin
        row_scan_reg <= preset_row_scan_reg[4:0];
        dscan_ph_reg <= 1'b0;
        row_addr_reg <= {display_start_high_reg, display_start_low_reg};
      end else if (vcnt_next[9:0] == lc_val) begin
        // split screen restarts memory at zero
        row_addr_reg <= 16'h0000;
        row_scan_reg <= 5'h00;
        dscan_ph_reg <= 1'b0;
      end else if (max_scan_line_reg[`CRT_MAX_DSCAN] && !dscan_ph_reg) begin
        dscan_ph_reg <= 1'b1;
      end else begin
        dscan_ph_reg <= 1'b0;
        if (row_scan_reg == max_row && vdisp_now) begin
          row_scan_reg <= 5'h00;
          row_addr_reg <= row_addr_reg + row_step;
        end else begin
          row_scan_reg <= row_scan_reg + 5'h01;
        end
      end
    end
  end

  // pen readback holds the address seen at line compare
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pen_readback_reg <= 16'h0000;
    end else if (line_end && vcnt_next[9:0] == lc_val) begin
      pen_readback_reg <= char_addr;
    end
  end

  // ----------------------------------------------------------------
  // skew lines for sync and cursor
  // ----------------------------------------------------------------
  crt_skew_if hs_if ();
  crt_skew_if cu_if ();

  assign hs_if.d   = hsync_raw_reg;
  assign hs_if.sel = hsync_end_reg[6:5];
  assign hs_if.en  = char_en;
  assign cu_if.d   = curs_line_ok && (char_addr ==
                     {cursor_location_high_reg, cursor_location_low_reg});
  assign cu_if.sel = cursor_end_reg[6:5];
  assign cu_if.en  = char_en;

  crt_skew #(.DEPTH(3)) u_hs_skew (
    .mclk (mclk),
    .rstn (rstn),
    .s    (hs_if)
  );

  crt_skew #(.DEPTH(3)) u_cu_skew (
    .mclk (mclk),
    .rstn (rstn),
    .s    (cu_if)
  );

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  // every output leaves from a flop so the monitor side sees no glitches
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      hsync          <= 1'b0;
      vsync          <= 1'b0;
      vdisp          <= 1'b0;
      cursor         <= 1'b0;
      underline      <= 1'b0;
      irq            <= 1'b0;
      row_scan       <= 5'h00;
      mem_addr       <= 16'h0000;
      byte_pan       <= 2'h0;
      hblank_end_b5  <= 1'b0;
      refresh_cycles <= `CRT_REFRESH_LO;
    end else begin
      hsync          <= hs_if.q;
      vsync          <= vsync_reg;
      vdisp          <= vdisp_now;
      cursor         <= cu_if.q;
      underline      <= (row_scan_reg == underline_location_reg[4:0] + `CRT_UL_ADD);
      irq            <= vint_reg;
      row_scan       <= row_scan_reg;
      mem_addr       <= char_addr;
      byte_pan       <= preset_row_scan_reg[6:5];
      hblank_end_b5  <= hsync_end_reg[7];
      refresh_cycles <= vsync_end_reg[`CRT_VSE_REFR] ? `CRT_REFRESH_HI
                                                     : `CRT_REFRESH_LO;
    end
  end
endmodule : crt_raster_timing_regs
`default_nettype wire

// ---- crt_raster_timing_regs_properties.sv ----
// port checker for the raster timing block
`timescale 1ns/1ps
`default_nettype none
`include "crt_params.svh"
// ---------------------------------------------
// checker
// ---------------------------------------------
module crt_chk #(
  parameter int CHAR_DIV = 8
) (
  input wire logic       mclk,
  input wire logic       rstn,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [5:0] reg_index,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       pen_sel,
  input wire logic       ext_protect,
  input wire logic       vsync,
  input wire logic       irq,
  input wire logic [1:0] byte_pan,
  input wire logic       hblank_end_b5,
  input wire logic [2:0] refresh_cycles
);
  logic [7:0] wd_q;
  logic [7:0] st_q;
  logic       pr_q;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // last write data, start high and protect bit shadows, only taken on a write
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wd_q <= 8'h00;
      st_q <= 8'h00;
      pr_q <= 1'b0;
    end else if (reg_wr) begin
      wd_q <= reg_wdata;
      if (reg_index == `CRT_IDX_START_HI) st_q <= reg_wdata;
      if (reg_index == `CRT_IDX_VSE) pr_q <= reg_wdata[`CRT_VSE_PROT];
    end
  end
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_refresh_legal: assert property (refresh_cycles == 3'h3 || refresh_cycles == 3'h5)
    else $error("refresh count not three or five");
  a_pen_hidden: assert property (reg_rd && pen_sel && reg_index[5:1] == 5'h08
    |=> reg_rdata == 8'h00)
    else $error("vsync register readable with pen select high");
  a_unmapped_zero: assert property (reg_rd && reg_index > 6'h14 |=> reg_rdata == 8'h00)
    else $error("unmapped index read not zero");
  a_irq_on_vsync: assert property ($rose(irq) |-> vsync)
    else $error("interrupt raised outside vsync");
  a_pan_follows: assert property (reg_wr && reg_index == `CRT_IDX_PRESET
    |-> ##[1:2] byte_pan == wd_q[6:5])
    else $error("byte pan not taken from preset write");
  a_b5_follows: assert property (reg_wr && !ext_protect && !pr_q && reg_index == `CRT_IDX_HSE
    |-> ##[1:2] hblank_end_b5 == wd_q[7])
    else $error("blank end bit5 not taken from write");
  a_protect_holds: assert property (reg_wr && (ext_protect || pr_q) && reg_index == `CRT_IDX_HSE
    |=> $stable(hblank_end_b5) [*2])
    else $error("protected write changed blank end bit5");
  a_start_readback: assert property (reg_rd && reg_index == `CRT_IDX_START_HI
    |=> reg_rdata == st_q)
    else $error("start high readback differs");
endmodule : crt_chk
bind crt_raster_timing_regs crt_chk #(.CHAR_DIV(CHAR_DIV)) u_chk (.mclk(mclk), .rstn(rstn),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_index(reg_index), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .pen_sel(pen_sel), .ext_protect(ext_protect), .vsync(vsync),
  .irq(irq), .byte_pan(byte_pan), .hblank_end_b5(hblank_end_b5),
  .refresh_cycles(refresh_cycles));
`default_nettype wire

// ---- crt_skew.sv ----
// programmable character-clock delay line
`timescale 1ns/1ps
`default_nettype none
module crt_skew #(
  parameter int DEPTH = 3
) (
  input wire logic mclk,
  input wire logic rstn,
  crt_skew_if.dly  s
);
  logic [DEPTH-1:0] sr_reg;

  // tap chain shifts only on character clock enables
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sr_reg <= '0;
      s.q    <= 1'b0;
    end else if (s.en) begin
      sr_reg <= {sr_reg[DEPTH-2:0], s.d};
      s.q    <= (s.sel == 2'h0) ? s.d : sr_reg[s.sel - 2'h1];
    end
  end
endmodule : crt_skew
`default_nettype wire

// ---- crt_skew_if.sv ----
// carrier between the timing core and one skew line
`timescale 1ns/1ps
`default_nettype none
interface crt_skew_if;
  logic       d;
  logic [1:0] sel;
  logic       en;
  logic       q;
  modport src (output d, sel, en, input q);
  modport dly (input d, sel, en, output q);
endinterface : crt_skew_if
`default_nettype wire

// ---- tb.sv ----
// testbench for the raster timing block
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------
// bench
// ---------------------------------------------
module tb;
  import crt_pkg::*;
  localparam int CD = 2;
  logic        mclk, rstn, reg_wr, reg_rd, pen_sel, ext_protect, ext_mode;
  logic        ext_hss_b8, ext_hse_b5, ext_vtot_b10, ext_vde_b10, ext_vss_b10;
  logic [5:0]  reg_index;
  logic [7:0]  reg_wdata, reg_rdata, htotal;
  logic [9:0]  line_compare;
  crt_mode_e   addr_mode;
  logic        hsync, vsync, vdisp, cursor, underline, irq, hblank_end_b5;
  logic [4:0]  row_scan;
  crt_addr_t   mem_addr;
  logic [1:0]  byte_pan;
  logic [2:0]  refresh_cycles;
  logic [15:0] h_period, h_width, v_period, v_width, vd_cnt;
  int          n_errors, num_checks;
  crt_raster_timing_regs #(.CHAR_DIV(CD)) u_dut (.mclk(mclk), .rstn(rstn), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_index(reg_index), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .pen_sel(pen_sel), .ext_protect(ext_protect), .ext_mode(ext_mode),
    .ext_hss_b8(ext_hss_b8), .ext_hse_b5(ext_hse_b5), .ext_vtot_b10(ext_vtot_b10),
    .ext_vde_b10(ext_vde_b10), .ext_vss_b10(ext_vss_b10), .htotal(htotal),
    .addr_mode(addr_mode), .line_compare(line_compare), .hsync(hsync), .vsync(vsync),
    .vdisp(vdisp), .cursor(cursor), .underline(underline), .irq(irq), .row_scan(row_scan),
    .mem_addr(mem_addr), .byte_pan(byte_pan), .hblank_end_b5(hblank_end_b5),
    .refresh_cycles(refresh_cycles));
  crt_mon u_mon (.mclk(mclk), .rstn(rstn), .hsync(hsync), .vsync(vsync), .vdisp(vdisp),
    .h_period(h_period), .h_width(h_width), .v_period(v_period), .v_width(v_width),
    .vd_cnt(vd_cnt));
  // free running clock, 4 ns
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic stop_test;
    if (n_errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // strobes rise 1 ns after an edge and fall after the taking edge
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    @(posedge mclk);
    #1;
    {reg_wr, reg_index, reg_wdata} = {1'b1, idx, d};
    @(posedge mclk);
    #1;
    reg_wr = 1'b0;
  endtask : wr
  task automatic rdc(input logic [5:0] idx, input logic [7:0] exp);
    @(posedge mclk);
    #1;
    {reg_rd, reg_index} = {1'b1, idx};
    @(posedge mclk);
    #1;
    reg_rd = 1'b0;
    chk(reg_rdata, exp);
  endtask : rdc
  task automatic t_reset;
    chk(refresh_cycles, 3'h3);
    chk(irq, 1'b0);
    rdc(6'h0C, 8'h00);
  endtask : t_reset
  // every register a distinct value, read back after all writes
  task automatic t_regs;
    logic [5:0] i;
    for (i = 6'h04; i <= 6'h14; i++) wr(i, {2'b00, i} ^ 8'h5A);
    for (i = 6'h04; i <= 6'h14; i++) rdc(i, i[5:1] == 5'h08 ? 8'h00 : {2'b00, i} ^ 8'h5A);
    rdc(6'h2A, 8'h00);
    chk(byte_pan, 2'b10);
    chk(hblank_end_b5, 1'b0);
    chk(refresh_cycles, 3'h5);
    wr(6'h11, 8'h13);
    repeat (2) @(posedge mclk);
    #1;
    chk(refresh_cycles, 3'h3);
  endtask : t_regs
  task automatic t_protect;
    ext_protect = 1'b1;
    wr(6'h05, 8'h80);
    wr(6'h04, 8'hEE);
    wr(6'h07, 8'h00);
    rdc(6'h04, 8'h5E);
    rdc(6'h07, 8'h4D);
    chk(hblank_end_b5, 1'b0);
    ext_protect = 1'b0;
    wr(6'h11, 8'h93);
    wr(6'h04, 8'h01);
    rdc(6'h04, 8'h5E);
    wr(6'h11, 8'h13);
  endtask : t_protect
  // 8 chars a line, 6 lines a frame, 2 display lines, sync widths 2 chars and 1 line
  task automatic t_timing;
    // restart so the short frame is entered from line zero, not past its end
    rstn = 1'b0;
    @(posedge mclk);
    #1;
    rstn = 1'b1;
    ext_mode = 1'b1;
    wr(6'h04, 8'h01);
    wr(6'h05, 8'h83);
    wr(6'h06, 8'h04);
    wr(6'h07, 8'h00);
    wr(6'h12, 8'h01);
    wr(6'h10, 8'h02);
    wr(6'h11, 8'h13);
    wr(6'h0C, 8'h12);
    wr(6'h0D, 8'h30);
    wr(6'h13, 8'h01);
    wr(6'h0E, 8'h12);
    wr(6'h0F, 8'h35);
    repeat (400) @(posedge mclk);
    #1;
    chk(h_period, 16'(8 * CD));
    chk(h_width, 16'(2 * CD));
    chk(v_period, 16'(6 * 8 * CD));
    chk(v_width, 16'(8 * CD));
    chk(vd_cnt, 16'(2 * 8 * CD));
    chk(hblank_end_b5, 1'b1);
    chk(irq, 1'b1);
    // third char of line 2: row start 1230h plus two pitch steps of 2
    @(posedge vsync);
    repeat (4) @(posedge mclk);
    #1;
    chk(mem_addr, 16'h1236);
    chk(row_scan, 5'h00);
    chk(cursor, 1'b1);
    chk(underline, 1'b0);
    wr(6'h11, 8'h03);
    repeat (2) @(posedge mclk);
    #1;
    chk(irq, 1'b0);
    wr(6'h11, 8'h33);
    // split at line 4 captures the last address of line 3
    {pen_sel, line_compare} = {1'b0, 10'h004};
    repeat (200) @(posedge mclk);
    #1;
    chk(irq, 1'b0);
    rdc(6'h10, 8'h12);
    rdc(6'h11, 8'h3B);
  endtask : t_timing
  // hang guard at 10000 cycles, far beyond the under 1000 cycles the run needs
  initial begin
    #40000;
    n_errors++;
    stop_test();
  end
  initial begin
    {rstn, reg_wr, reg_rd, ext_protect, ext_mode, ext_hss_b8, ext_hse_b5} = '0;
    {ext_vtot_b10, ext_vde_b10, ext_vss_b10, reg_index, reg_wdata} = '0;
    {pen_sel, htotal, line_compare, addr_mode} = {1'b1, 8'h03, 10'h3FF, CRT_BYTE};
    {n_errors, num_checks} = '0;
    repeat (8) @(posedge mclk);
    #1;
    rstn = 1'b1;
    t_reset();
    t_regs();
    t_protect();
    t_timing();
    stop_test();
  end
endmodule : tb
`default_nettype wire
